/* File: common/mrrc_pkg.sv */
/*
  constants, types and register map of the memory remap and reset cause
  block; assumes a single 125 MHz core clock and an apb master.
*/
package mrrc_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses, low 12 bits)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_SWAP       = 12'h220; // swap control
  localparam logic [11:0] OFF_STATUS     = 12'h230; // reset cause status
  localparam logic [11:0] OFF_CLEAR      = 12'h234; // reset cause clear
  localparam logic [11:0] OFF_KEY_FIRST  = 12'h248; // first key
  localparam logic [11:0] OFF_CONFIG     = 12'h24C; // retention config
  localparam logic [11:0] OFF_KEY_SECOND = 12'h250; // second key
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h260; // sticky events
  localparam logic [11:0] OFF_IRQ_ENABLE = 12'h264; // event enables
  localparam logic [11:0] OFF_IRQ_CLEAR  = 12'h268; // event clear

  // ----------------------------------------------------------------
  // codes, field positions, reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] KEY_FIRST     = 8'h76; // opens config write
  localparam logic [7:0] KEY_SECOND    = 8'hB1; // commits config
  localparam logic [2:0] CLEAR_ALL     = 3'h7;  // wipes all causes
  localparam logic [7:0] CONFIG_RESET  = 8'h05; // gpio and dac kept
  localparam logic [7:0] CONFIG_MASK   = 8'h05; // writable config bits
  localparam logic [2:0] CAUSE_RESET   = 3'h1;  // power-on flag
  localparam int         CAUSE_POR     = 0;     // power-on bit
  localparam int         CAUSE_WDT     = 1;     // watchdog bit
  localparam int         CAUSE_SW      = 2;     // software bit
  localparam int         CFG_GPIO      = 0;     // keep gpio state
  localparam int         CFG_DAC       = 2;     // keep dac state
  localparam int         SWAP_BIT      = 0;     // swap control bit
  localparam int         IRQ_W         = 4;     // event count
  localparam int         IRQ_WDT       = 0;     // watchdog reset seen
  localparam int         IRQ_SW        = 1;     // software reset seen
  localparam int         IRQ_KEYERR    = 2;     // bad key sequence
  localparam int         IRQ_COMMIT    = 3;     // config committed

  // ----------------------------------------------------------------
  // memory map
  // ----------------------------------------------------------------
  localparam logic [31:0] VECTOR_LOW   = 32'h0000_0000; // first vector
  localparam logic [31:0] VECTOR_HIGH  = 32'h0000_0020; // vector top
  localparam logic [31:0] MIRROR_BYTES = 32'h0008_0000; // mirror window
  localparam logic [31:0] FLASH_BASE   = 32'h0008_0000; // flash home
  localparam logic [31:0] FLASH_BYTES  = 32'h0002_0000; // flash size
  localparam logic [31:0] SRAM_BASE    = 32'h0001_0000; // sram home
  localparam logic [31:0] SRAM_BYTES   = 32'h0000_8000; // sram size

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS         = 8;    // 125 MHz core clock
  localparam int HOLD_NS        = 128;  // least reset hold time
  localparam int KERNEL_NS      = 2048; // kernel configuration run
  localparam int HOLD_CYCLES    = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int KERNEL_CYCLES  = (KERNEL_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_HOLD   = 2'b00, // core held in reset
    ST_KERNEL = 2'b01, // hidden kernel configures
    ST_USER   = 2'b10, // user code from zero vector
    ST_LOADER = 2'b11  // boot pin low, kernel stays
  } mrrc_state_t;

  typedef enum logic [1:0] {
    KS_IDLE   = 2'b00, // no sequence open
    KS_ARMED  = 2'b01, // first key seen
    KS_LOADED = 2'b10  // value staged
  } mrrc_key_t;

  typedef struct packed {
    logic        flash;  // access goes to flash
    logic        sram;   // access goes to sram
    logic        vector; // access hits the vector region
    logic [31:0] offset; // offset inside the target
  } mrrc_mem_sel_t;

  typedef struct packed {
    logic core_reset_n; // core and bus peripherals
    logic gpio_reset_n; // gpio pins and registers
    logic dac_reset_n;  // dac outputs and registers
  } mrrc_rst_t;

endpackage

/* File: logic/mrrc_top.sv */
/*
  memory remap and reset cause block: apb registers, low memory mirror
  decode, reset sequencing with cause record and retention control.
  assumes presetn is the power-on reset; pin and watchdog resets arrive as pins, software reset via the status register.
*/
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ns
module mrrc_top #(
  parameter int HOLD_CYCLES   = mrrc_pkg::HOLD_CYCLES,  // reset hold
  parameter int KERNEL_CYCLES = mrrc_pkg::KERNEL_CYCLES // kernel run
) (
  input  wire logic                   pclk,            // core clock
  input  wire logic                   presetn,         // power-on reset
  input  wire logic                   psel,            // apb select
  input  wire logic                   penable,         // apb access
  input  wire logic                   pwrite,          // apb direction
  input  wire logic [11:0]            paddr,           // apb address
  input  wire logic [31:0]            pwdata,          // apb write data
  output logic                        pready,          // apb ready
  output logic [31:0]                 prdata,          // apb read data
  output logic                        pslverr,         // unmapped
  input  wire logic                   ext_reset_n,     // reset pin
  input  wire logic                   wdt_timeout,     // watchdog expiry
  input  wire logic                   boot_select_pin, // high: normal
  input  wire logic                   mem_req,         // core access
  input  wire logic [31:0]            mem_addr,        // core address
  output mrrc_pkg::mrrc_mem_sel_t     mem_sel,         // decoded target
  output mrrc_pkg::mrrc_rst_t         rst_out,         // reset outputs
  output logic                        kernel_active,   // kernel running
  output logic                        user_start,      // jump to zero
  output logic                        irq              // event interrupt
);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [2:0]            sync1;        // first stage, read by sync2 only
  logic [2:0]            sync2;        // {boot, wdt, ext_n} synchronised
  logic                  wdt_prev;     // watchdog edge history
  logic                  wdt_rise;     // watchdog expiry event
  logic                  ext_low;      // reset pin asserted
  logic                  boot_high;    // normal boot mode
  mrrc_pkg::mrrc_state_t state;        // reset sequencer state
  logic [15:0]           cnt;          // hold and kernel counter
  logic                  retain_kind;  // last reset was wdt or software
  logic                  swap;         // sram mirrored at zero
  logic [2:0]            cause;        // reset cause record
  logic [7:0]            config_q;     // retention config
  logic [7:0]            pending;      // staged config value
  mrrc_pkg::mrrc_key_t   ks;           // key sequence state
  logic [3:0]            irq_status;   // sticky events
  logic [3:0]            irq_enable;   // event enables
  logic [3:0]            irq_set;      // events this cycle
  logic                  wr;           // completing write
  logic                  sw_req;       // software force reset
  logic                  key_err;      // out of order key access
  logic                  commit;       // second key accepted
  logic [31:0]           rd_data;      // read mux
  logic                  mapped;       // address decodes

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // two flops per pin; the edge detector sits behind the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1    <= 3'h1;
      sync2    <= 3'h1;
      wdt_prev <= 1'b0;
    end else begin
      sync1    <= {boot_select_pin, wdt_timeout, ext_reset_n};
      sync2    <= sync1;
      wdt_prev <= sync2[1];
    end
  end

  assign ext_low   = !sync2[0];
  assign wdt_rise  = sync2[1] && !wdt_prev;
  assign boot_high = sync2[2];

  // ----------------------------------------------------------------
  // apb slave, one wait state
  // ----------------------------------------------------------------
  assign wr = psel && penable && pready && pwrite;

  // read mux; write-only registers read zero
  always_comb begin
    rd_data = 32'h0000_0000;
    mapped  = 1'b1;
    case (paddr)
      mrrc_pkg::OFF_SWAP:       rd_data = {31'h0, swap};
      mrrc_pkg::OFF_STATUS:     rd_data = {29'h0, cause};
      mrrc_pkg::OFF_CONFIG:     rd_data = {24'h0, config_q};
      mrrc_pkg::OFF_IRQ_STATUS: rd_data = {28'h0, irq_status};
      mrrc_pkg::OFF_IRQ_ENABLE: rd_data = {28'h0, irq_enable};
      mrrc_pkg::OFF_CLEAR,
      mrrc_pkg::OFF_KEY_FIRST,
      mrrc_pkg::OFF_KEY_SECOND,
      mrrc_pkg::OFF_IRQ_CLEAR:  rd_data = 32'h0000_0000;
      default:                  mapped  = 1'b0; // unmapped: error
    endcase
  end

  // ready rises in the second access cycle, data held with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h0000_0000 : rd_data;
      pslverr <= !mapped;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // writing bit 2 at the status offset forces a software reset
  assign sw_req = wr && paddr == mrrc_pkg::OFF_STATUS &&
                  pwdata[mrrc_pkg::CAUSE_SW];

  // ----------------------------------------------------------------
  // reset sequencer
  // ----------------------------------------------------------------
  // pin reset wins over watchdog and software, which act alike
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= mrrc_pkg::ST_HOLD;
      cnt         <= 16'h0000;
      retain_kind <= 1'b0;
    end else if (ext_low) begin
      state       <= mrrc_pkg::ST_HOLD;
      cnt         <= 16'h0000;
      retain_kind <= 1'b0;
    end else if ((wdt_rise || sw_req) && state != mrrc_pkg::ST_HOLD) begin
      state       <= mrrc_pkg::ST_HOLD;
      cnt         <= 16'h0000;
      retain_kind <= 1'b1;
    end else begin
      case (state)
        mrrc_pkg::ST_HOLD: begin
          if (cnt == 16'(HOLD_CYCLES - 1)) begin
            state <= mrrc_pkg::ST_KERNEL;
            cnt   <= 16'h0000;
          end else begin
            cnt <= cnt + 16'h0001;
          end
        end
        mrrc_pkg::ST_KERNEL: begin
          if (cnt == 16'(KERNEL_CYCLES - 1)) begin
            // download mode keeps the kernel in charge
            state <= boot_high ? mrrc_pkg::ST_USER
                               : mrrc_pkg::ST_LOADER;
            cnt   <= 16'h0000;
          end else begin
            cnt <= cnt + 16'h0001;
          end
        end
        mrrc_pkg::ST_USER:   state <= mrrc_pkg::ST_USER;
        mrrc_pkg::ST_LOADER: state <= mrrc_pkg::ST_LOADER;
        default:             state <= mrrc_pkg::ST_HOLD;
      endcase
    end
  end

  // registered reset outputs; retained blocks skip wdt and sw resets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_out       <= '0;
      kernel_active <= 1'b0;
      user_start    <= 1'b0;
    end else begin
      rst_out.core_reset_n <= state != mrrc_pkg::ST_HOLD;
      rst_out.gpio_reset_n <= state != mrrc_pkg::ST_HOLD ||
        (retain_kind && config_q[mrrc_pkg::CFG_GPIO]);
      rst_out.dac_reset_n  <= state != mrrc_pkg::ST_HOLD ||
        (retain_kind && config_q[mrrc_pkg::CFG_DAC]);
      kernel_active <= state == mrrc_pkg::ST_KERNEL ||
                       state == mrrc_pkg::ST_LOADER;
      user_start    <= state == mrrc_pkg::ST_KERNEL &&
                       cnt == 16'(KERNEL_CYCLES - 1) &&
                       boot_high && !ext_low;
    end
  end

  sequence s_kernel_end;
    state == mrrc_pkg::ST_KERNEL && cnt == 16'(KERNEL_CYCLES - 1) &&
    boot_high && !ext_low && !wdt_rise && !sw_req;
  endsequence
  sequence s_user_entry;
    state == mrrc_pkg::ST_USER && user_start ##1 !user_start;
  endsequence
  property p_boot_user;
    s_kernel_end |=> s_user_entry;
  endproperty
  a_boot_user: assert property (p_boot_user)
    else $error("kernel did not hand over to user code");

  // hold length follows the parameter, so it is tied to the counter
  property p_hold_time;
    state == mrrc_pkg::ST_HOLD && cnt != 16'(HOLD_CYCLES - 1) |=>
      state == mrrc_pkg::ST_HOLD;
  endproperty
  a_hold_time: assert property (p_hold_time)
    else $error("reset hold ended too early");

  property p_retain_gpio;
    state == mrrc_pkg::ST_HOLD && retain_kind &&
    config_q[mrrc_pkg::CFG_GPIO] |=> rst_out.gpio_reset_n &&
    !rst_out.core_reset_n;
  endproperty
  a_retain_gpio: assert property (p_retain_gpio)
    else $error("retained gpio was reset");

  // ----------------------------------------------------------------
  // reset cause record
  // ----------------------------------------------------------------
  // hardware sets win over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause <= mrrc_pkg::CAUSE_RESET;
    end else if (ext_low) begin
      cause <= 3'h0;
    end else begin
      cause <= ((wr && paddr == mrrc_pkg::OFF_CLEAR) ?
                (cause & ~pwdata[2:0]) : cause) |
               {sw_req && state != mrrc_pkg::ST_HOLD,
                wdt_rise && state != mrrc_pkg::ST_HOLD,
                1'b0};
    end
  end

  property p_cause_ext;
    ext_low |=> cause == 3'h0 && state == mrrc_pkg::ST_HOLD ##1
                !rst_out.core_reset_n;
  endproperty
  a_cause_ext: assert property (p_cause_ext)
    else $error("pin reset left cause flags set");

  property p_cause_wdt;
    wdt_rise && !ext_low && state != mrrc_pkg::ST_HOLD |=>
      cause[mrrc_pkg::CAUSE_WDT] && state == mrrc_pkg::ST_HOLD;
  endproperty
  a_cause_wdt: assert property (p_cause_wdt)
    else $error("watchdog reset not recorded");

  property p_cause_clear;
    wr && paddr == mrrc_pkg::OFF_CLEAR &&
    pwdata[2:0] == mrrc_pkg::CLEAR_ALL && !ext_low && !wdt_rise &&
    !sw_req |=> cause == 3'h0;
  endproperty
  a_cause_clear: assert property (p_cause_clear)
    else $error("clear register did not wipe causes");

  // ----------------------------------------------------------------
  // retention config with key sequence
  // ----------------------------------------------------------------
  assign commit  = ks == mrrc_pkg::KS_LOADED && wr &&
                   paddr == mrrc_pkg::OFF_KEY_SECOND &&
                   pwdata[7:0] == mrrc_pkg::KEY_SECOND;
  assign key_err = wr && !commit &&
    ((paddr == mrrc_pkg::OFF_CONFIG && ks != mrrc_pkg::KS_ARMED) ||
     (paddr == mrrc_pkg::OFF_KEY_SECOND) ||
     (paddr == mrrc_pkg::OFF_KEY_FIRST &&
      pwdata[7:0] != mrrc_pkg::KEY_FIRST));

  // config survives wdt and sw resets; only power-on restores it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ks       <= mrrc_pkg::KS_IDLE;
      pending  <= 8'h00;
      config_q <= mrrc_pkg::CONFIG_RESET;
    end else if (commit) begin
      config_q <= pending;
      ks       <= mrrc_pkg::KS_IDLE;
    end else if (key_err) begin
      ks <= mrrc_pkg::KS_IDLE;
    end else if (wr && paddr == mrrc_pkg::OFF_KEY_FIRST) begin
      ks <= mrrc_pkg::KS_ARMED;
    end else if (wr && paddr == mrrc_pkg::OFF_CONFIG) begin
      pending <= pwdata[7:0] & mrrc_pkg::CONFIG_MASK;
      ks      <= mrrc_pkg::KS_LOADED;
    end
  end

  property p_commit;
    commit |=> config_q == $past(pending) && ks == mrrc_pkg::KS_IDLE;
  endproperty
  a_commit: assert property (p_commit)
    else $error("config not committed by second key");

  property p_no_key;
    ks == mrrc_pkg::KS_IDLE |=> config_q == $past(config_q);
  endproperty
  a_no_key: assert property (p_no_key)
    else $error("config changed without key sequence");

  // ----------------------------------------------------------------
  // swap control and low memory decode
  // ----------------------------------------------------------------
  // cleared while any reset holds the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swap <= 1'b0;
    end else if (state == mrrc_pkg::ST_HOLD) begin
      swap <= 1'b0;
    end else if (wr && paddr == mrrc_pkg::OFF_SWAP) begin
      swap <= pwdata[mrrc_pkg::SWAP_BIT];
    end
  end

  // decode uses swap as it stood before this edge, so a write only
  // steers accesses presented after it has completed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_sel <= '0;
    end else if (!mem_req) begin
      mem_sel <= '0;
    end else begin
      mem_sel.vector <= mem_addr <= mrrc_pkg::VECTOR_HIGH;
      if (mem_addr < mrrc_pkg::MIRROR_BYTES) begin
        mem_sel.flash  <= !swap;
        mem_sel.sram   <= swap;
        mem_sel.offset <= mem_addr;
      end else if (mem_addr >= mrrc_pkg::FLASH_BASE &&
                   mem_addr < mrrc_pkg::FLASH_BASE +
                              mrrc_pkg::FLASH_BYTES) begin
        mem_sel.flash  <= 1'b1;
        mem_sel.sram   <= 1'b0;
        mem_sel.offset <= mem_addr - mrrc_pkg::FLASH_BASE;
      end else if (mem_addr >= mrrc_pkg::SRAM_BASE &&
                   mem_addr < mrrc_pkg::SRAM_BASE +
                              mrrc_pkg::SRAM_BYTES) begin
        mem_sel.flash  <= 1'b0;
        mem_sel.sram   <= 1'b1;
        mem_sel.offset <= mem_addr - mrrc_pkg::SRAM_BASE;
      end else begin
        mem_sel.flash  <= 1'b0; // outside both memories
        mem_sel.sram   <= 1'b0;
        mem_sel.offset <= 32'h0000_0000;
      end
    end
  end

  property p_swap_reset;
    state == mrrc_pkg::ST_HOLD |=> !swap;
  endproperty
  a_swap_reset: assert property (p_swap_reset)
    else $error("swap survived a reset");

  property p_mirror;
    mem_req && mem_addr < mrrc_pkg::MIRROR_BYTES |=>
      mem_sel.sram == $past(swap) && mem_sel.flash == !$past(swap);
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("low region decoded to wrong memory");

  property p_swap_back;
    wr && paddr == mrrc_pkg::OFF_SWAP && !pwdata[mrrc_pkg::SWAP_BIT]
    ##[1:3] mem_req && mem_addr < mrrc_pkg::MIRROR_BYTES |=> mem_sel.flash;
  endproperty
  a_swap_back: assert property (p_swap_back)
    else $error("flash not restored at zero");

  property p_vector;
    mem_req && mem_addr <= mrrc_pkg::VECTOR_HIGH |=> mem_sel.vector;
  endproperty
  a_vector: assert property (p_vector)
    else $error("vector region not flagged");

  // ----------------------------------------------------------------
  // interrupt events
  // ----------------------------------------------------------------
  assign irq_set = {commit, key_err,
                    sw_req && state != mrrc_pkg::ST_HOLD,
                    wdt_rise && state != mrrc_pkg::ST_HOLD};

  // sticky status; a new event wins over its clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 4'h0;
      irq_enable <= 4'h0;
      irq        <= 1'b0;
    end else begin
      irq_status <= ((wr && paddr == mrrc_pkg::OFF_IRQ_CLEAR) ?
                     (irq_status & ~pwdata[3:0]) : irq_status) | irq_set;
      if (wr && paddr == mrrc_pkg::OFF_IRQ_ENABLE) begin
        irq_enable <= pwdata[3:0];
      end
      irq <= |(irq_status & irq_enable);
    end
  end

  property p_irq;
    1'b1 |=> irq == |($past(irq_status) & $past(irq_enable));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt output mismatches status");

endmodule

/* File: testbench/mrrc_core_model.sv */
/* core side model: one memory access per bench request.
   assumes req_in is held for a single cycle. */
`timescale 1ns/1ns
module mrrc_core_model (
  input  wire logic        pclk,    // core clock
  input  wire logic        presetn, // power-on reset
  input  wire logic        req_in,  // bench asks for an access
  input  wire logic [31:0] addr_in, // access address
  output logic             mem_req, // access request
  output logic [31:0]      mem_addr // released bus flips, never stale
);
  // one access per request, idle address inverted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_req  <= 1'b0;
      mem_addr <= 32'h0000_0000; // reset fetch from flash vector
    end else begin
      mem_req  <= req_in;
      mem_addr <= req_in ? addr_in : ~mem_addr;
    end
  end
endmodule

/* File: testbench/test_memory_remap_reset_cause.sv */
/* bench for mrrc_top: apb tasks, core model, reference values.
   assumes small hold and kernel counts, boot pin high until the last test. */
`timescale 1ns/1ns
`define CHK(a,b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module test_memory_remap_reset_cause;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, mem_addr, addr_in;
  logic ext_reset_n, wdt_timeout, mem_req, req_in, kernel_active, user_start;
  logic boot_pin; // boot select pin level
  mrrc_pkg::mrrc_mem_sel_t mem_sel;
  mrrc_pkg::mrrc_rst_t     rst_out;
  int n_errors = 0, n_tests = 0, cyc = 0, k;
  logic [31:0] exp_swap, exp_cause, exp_cfg;
  mrrc_top #(.HOLD_CYCLES(2), .KERNEL_CYCLES(4)) dut (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .ext_reset_n, .wdt_timeout, .boot_select_pin(boot_pin), .mem_req,
    .mem_addr, .mem_sel, .rst_out, .kernel_active, .user_start, .irq);
  mrrc_core_model core (.pclk, .presetn, .req_in, .addr_in, .mem_req,
    .mem_addr);
  initial begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one apb transfer, request held until pready
  task automatic apb(input bit w, input logic [11:0] a, input logic [31:0] d);
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // ready, data and error are taken at the rising edge itself
    do @(posedge pclk); while (pready !== 1'b1 && ++k < 20);
    if (pready !== 1'b1) n_errors++; // no answer counts as a mismatch
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    `CHK(rd, e)
  endtask
  // low window follows swap, flash home never moves
  task automatic probe(input logic [31:0] a);
    logic [34:0] e;
    e = (a < 32'h0008_0000) ? {~exp_swap[0], exp_swap[0], a <= 32'h20, a}
        : {3'b100, a - 32'h0008_0000};
    @(posedge pclk);
    req_in <= 1'b1;
    addr_in <= a;
    @(posedge pclk);
    req_in <= 1'b0;
    @(posedge pclk);
    @(negedge pclk);
    `CHK(mem_sel, e)
  endtask
  task automatic wait_user(input bit rst);
    logic [1:0] e;
    k = 0;
    if (rst) do @(negedge pclk);
      while (rst_out.core_reset_n !== 0 && ++k < 50);
    e = {exp_cfg[0], exp_cfg[2]};
    if (rst) `CHK({rst_out.gpio_reset_n, rst_out.dac_reset_n}, e)
    do @(negedge pclk); while (user_start !== 1'b1 && ++k < 100);
    `CHK(user_start, 1'b1)
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {wdt_timeout, req_in, addr_in} = '0;
    {ext_reset_n, boot_pin} = 2'b11;
    {exp_swap, exp_cause, exp_cfg} = {32'h0, 32'h1, 32'h5};
    void'($urandom(62364));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wait_user(0);
    rchk(mrrc_pkg::OFF_STATUS, exp_cause);
    rchk(mrrc_pkg::OFF_CONFIG, exp_cfg);
    rchk(mrrc_pkg::OFF_SWAP, exp_swap);
    for (int i = 0; i < 6; i++) begin
      exp_swap = i % 2;
      apb(1, mrrc_pkg::OFF_SWAP, exp_swap);
      probe($urandom % 64);
      probe(32'h0008_0020 + $urandom % 64);
    end
    apb(1, 12'h004, 1);
    `CHK(err, 1'b1)
    apb(1, mrrc_pkg::OFF_CLEAR, 7);
    rchk(mrrc_pkg::OFF_STATUS, 0);
    exp_cfg = $urandom & 5;
    apb(1, mrrc_pkg::OFF_KEY_FIRST, 32'h76);
    apb(1, mrrc_pkg::OFF_CONFIG, exp_cfg);
    apb(1, mrrc_pkg::OFF_KEY_SECOND, 32'hB1);
    apb(1, mrrc_pkg::OFF_CONFIG, ~exp_cfg & 5);
    rchk(mrrc_pkg::OFF_CONFIG, exp_cfg);
    apb(1, mrrc_pkg::OFF_IRQ_ENABLE, 2);
    apb(1, mrrc_pkg::OFF_STATUS, 4);
    wait_user(1);
    exp_swap = 0;
    rchk(mrrc_pkg::OFF_STATUS, 4);
    rchk(mrrc_pkg::OFF_SWAP, 0);
    probe(0);
    `CHK(irq, 1'b1)
    apb(1, mrrc_pkg::OFF_IRQ_CLEAR, 2);
    repeat (2) @(negedge pclk);
    `CHK(irq, 1'b0)
    @(posedge pclk) wdt_timeout <= 1'b1;
    @(posedge pclk) wdt_timeout <= 1'b0;
    wait_user(1);
    rchk(mrrc_pkg::OFF_STATUS, 6);
    @(posedge pclk) ext_reset_n <= 1'b0;
    repeat (3) @(posedge pclk);
    ext_reset_n <= 1'b1;
    wait_user(0);
    rchk(mrrc_pkg::OFF_STATUS, 0);
    `CHK(kernel_active, 1'b0)
    // boot pin low: the kernel keeps control, no jump to zero
    boot_pin <= 1'b0;
    @(posedge pclk) ext_reset_n <= 1'b0;
    repeat (3) @(posedge pclk);
    ext_reset_n <= 1'b1;
    repeat (40) @(negedge pclk);
    `CHK({kernel_active, rst_out.core_reset_n, user_start}, 3'b110)
    give_verdict();
  end
endmodule
